// file: hw/two_wire_master.sv
// Two-wire serial bus master that sequences whole transfers from one command.
// Assumes external pull-ups on both lines and a user that streams write bytes on request.
`timescale 1ns/1ps
`include "two_wire_cfg.svh"

module two_wire_master #(
  parameter int MAX_BYTES = `TW_MAX_BYTES
) (
  input  wire logic                        core_clk,   // Core clock, 100 MHz.
  input  wire logic                        arst_n,     // Asynchronous reset, active low.
  input  wire logic                        enable,     // Block enable.
  input  wire logic                        start,      // Start a transfer, one-cycle pulse.
  input  wire two_wire_pkg::xfer_e         xfer_type,  // Transfer kind.
  input  wire two_wire_pkg::rate_e         rate,       // Bus clock rate.
  input  wire logic [6:0]                  slave_addr, // Seven-bit slave address.
  input  wire logic [4:0]                  rd_len,     // Bytes to read, 1 to MAX_BYTES.
  input  wire logic [4:0]                  wr_len,     // Bytes to write, 1 to MAX_BYTES.
  input  wire logic [7:0]                  tx_byte,    // Next byte to write.
  output logic                             tx_take,    // Pulse: tx_byte was taken.
  output logic [7:0]                       rx_byte,    // Last byte read.
  output logic                             rx_valid,   // Pulse: rx_byte is new.
  output logic                             busy,       // Transfer in progress.
  output logic                             done,       // Pulse: transfer finished.
  output logic                             nack_err,   // Last transfer met a NACK.
  output logic                             clk_req,    // Request for the shared oscillator.
  input  wire logic                        scl_i,      // Clock line level.
  output logic                             scl_o,      // Clock line drive value.
  output logic                             scl_oe_n,   // Clock line drive enable, low drives.
  input  wire logic                        sda_i,      // Data line level.
  output logic                             sda_o,      // Data line drive value.
  output logic                             sda_oe_n    // Data line drive enable, low drives.
);

  localparam int CW = `TW_CNT_W;
  localparam logic [CW-1:0] HOLD = CW'(`TW_HOLD_CYC);

  if (MAX_BYTES < 1 || MAX_BYTES > 31)
  begin : g_chk
    $error("MAX_BYTES must lie between 1 and 31.");
  end

  function automatic logic [CW-1:0] qcyc(input two_wire_pkg::rate_e r);
    unique case (r)
      two_wire_pkg::RATE_100K: qcyc = CW'(`TW_QCYC(`TW_RATE_100K_HZ));
      two_wire_pkg::RATE_400K: qcyc = CW'(`TW_QCYC(`TW_RATE_400K_HZ));
      two_wire_pkg::RATE_800K: qcyc = CW'(`TW_QCYC(`TW_RATE_800K_HZ));
      two_wire_pkg::RATE_1M:   qcyc = CW'(`TW_QCYC(`TW_RATE_1M_HZ));
    endcase
  endfunction

  function automatic logic len_ok(input logic [4:0] n);
    len_ok = (n != 5'h00) && (32'(n) <= MAX_BYTES);
  endfunction

  two_wire_pkg::tw_state_e state_q, state_d;
  two_wire_pkg::xfer_e     type_q, type_d;
  logic [CW-1:0] cnt_q, cnt_d, q_q, q_d;
  logic [3:0]    bit_q, bit_d;
  logic [7:0]    sh_q, sh_d, rx_q, rx_d;
  logic [6:0]    addr_q, addr_d;
  logic [4:0]    rlen_q, rlen_d, wlen_q, wlen_d, left_q, left_d;
  logic          is_addr_q, is_addr_d, rd_ph_q, rd_ph_d, second_q, second_d;
  logic          scl_low_q, scl_low_d, sda_low_q, sda_low_d, ack_bad_q, ack_bad_d;
  logic          busy_q, busy_d, done_q, done_d, nack_q, nack_d;
  logic          rxv_q, rxv_d, take_q, take_d, req_q, req_d;
  logic          bit_end, driving, first_rd;

  // Clock stretching is not honoured, so the clock line level is never consulted.
  logic unused_scl;
  assign unused_scl = scl_i;

  always_comb
  begin
    state_d   = state_q;
    type_d    = type_q;
    q_d       = q_q;
    cnt_d     = cnt_q + CW'(1);
    bit_d     = bit_q;
    sh_d      = sh_q;
    rx_d      = rx_q;
    addr_d    = addr_q;
    rlen_d    = rlen_q;
    wlen_d    = wlen_q;
    left_d    = left_q;
    is_addr_d = is_addr_q;
    rd_ph_d   = rd_ph_q;
    second_d  = second_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    ack_bad_d = ack_bad_q;
    busy_d    = busy_q;
    nack_d    = nack_q;
    done_d    = 1'b0;
    rxv_d     = 1'b0;
    take_d    = 1'b0;
    req_d     = enable;
    bit_end   = (cnt_q == {q_q[CW-3:0], 2'b00} - CW'(1));
    driving   = is_addr_q || !rd_ph_q;
    first_rd  = (xfer_type == two_wire_pkg::XF_READ) || (xfer_type == two_wire_pkg::XF_RD_WR);
    unique case (state_q)
      two_wire_pkg::ST_IDLE:
      begin
        cnt_d     = '0;
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
        // A command with an unusable length for a phase it needs is ignored.
        if (start && enable
            && (xfer_type == two_wire_pkg::XF_WRITE || len_ok(rd_len))
            && (xfer_type == two_wire_pkg::XF_READ || len_ok(wr_len)))
        begin
          state_d  = two_wire_pkg::ST_START;
          type_d   = xfer_type;
          q_d      = qcyc(rate);
          addr_d   = slave_addr;
          rlen_d   = rd_len;
          wlen_d   = wr_len;
          rd_ph_d  = first_rd;
          second_d = xfer_type[1];
          busy_d   = 1'b1;
          nack_d   = 1'b0;
        end
      end
      two_wire_pkg::ST_START:
      begin
        // Both lines high for half a bit, then data falls while the clock is high.
        scl_low_d = 1'b0;
        sda_low_d = (cnt_q >= {q_q[CW-2:0], 1'b0});
        if (bit_end)
        begin
          state_d   = two_wire_pkg::ST_BYTE;
          cnt_d     = '0;
          bit_d     = 4'h0;
          is_addr_d = 1'b1;
          sh_d      = {addr_q, rd_ph_q};
        end
      end
      two_wire_pkg::ST_BYTE:
      begin
        scl_low_d = (cnt_q < {q_q[CW-2:0], 1'b0});
        if (cnt_q == HOLD)
        begin
          if (bit_q < 4'h8)
            sda_low_d = driving && !sh_q[7];
          else
            sda_low_d = !driving && (left_q != 5'h01);
        end
        if (cnt_q == (q_q + {q_q[CW-2:0], 1'b0}))
        begin
          if (bit_q == 4'h8)
            ack_bad_d = sda_i;
          else if (!driving)
            sh_d = {sh_q[6:0], sda_i};
        end
        if (bit_end)
        begin
          cnt_d = '0;
          if (bit_q < 4'h8)
          begin
            bit_d = bit_q + 4'h1;
            if (driving)
              sh_d = {sh_q[6:0], 1'b0};
            else if (bit_q == 4'h7)
            begin
              rx_d  = sh_q;
              rxv_d = 1'b1;
            end
          end
          else
          begin
            bit_d = 4'h0;
            if (driving && ack_bad_q)
            begin
              state_d = two_wire_pkg::ST_STOP;
              nack_d  = 1'b1;
            end
            else if (is_addr_q)
            begin
              is_addr_d = 1'b0;
              left_d    = rd_ph_q ? rlen_q : wlen_q;
              if (!rd_ph_q)
              begin
                sh_d   = tx_byte;
                take_d = 1'b1;
              end
            end
            else
            begin
              left_d = left_q - 5'h01;
              if (left_q == 5'h01)
              begin
                if (second_q)
                begin
                  state_d  = two_wire_pkg::ST_RESTART;
                  second_d = 1'b0;
                  rd_ph_d  = !rd_ph_q;
                end
                else
                  state_d = two_wire_pkg::ST_STOP;
              end
              else if (!rd_ph_q)
              begin
                sh_d   = tx_byte;
                take_d = 1'b1;
              end
            end
          end
        end
      end
      two_wire_pkg::ST_RESTART:
      begin
        // Clock low for half a bit with data released, then a fresh start.
        scl_low_d = 1'b1;
        if (cnt_q == HOLD)
          sda_low_d = 1'b0;
        if (cnt_q == {q_q[CW-2:0], 1'b0} - CW'(1))
        begin
          state_d = two_wire_pkg::ST_START;
          cnt_d   = '0;
        end
      end
      two_wire_pkg::ST_STOP:
      begin
        scl_low_d = (cnt_q < {q_q[CW-2:0], 1'b0});
        if (cnt_q == HOLD)
          sda_low_d = 1'b1;
        if (cnt_q >= (q_q + {q_q[CW-2:0], 1'b0}))
          sda_low_d = 1'b0;
        if (bit_end)
        begin
          state_d = two_wire_pkg::ST_IDLE;
          busy_d  = 1'b0;
          done_d  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= two_wire_pkg::ST_IDLE;
      type_q    <= two_wire_pkg::XF_READ;
      q_q       <= CW'(`TW_QCYC(`TW_RATE_100K_HZ));
      cnt_q     <= '0;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      rx_q      <= 8'h00;
      addr_q    <= 7'h00;
      rlen_q    <= 5'h00;
      wlen_q    <= 5'h00;
      left_q    <= 5'h00;
      is_addr_q <= 1'b0;
      rd_ph_q   <= 1'b0;
      second_q  <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      ack_bad_q <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      nack_q    <= 1'b0;
      rxv_q     <= 1'b0;
      take_q    <= 1'b0;
      req_q     <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      type_q    <= type_d;
      q_q       <= q_d;
      cnt_q     <= cnt_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      rx_q      <= rx_d;
      addr_q    <= addr_d;
      rlen_q    <= rlen_d;
      wlen_q    <= wlen_d;
      left_q    <= left_d;
      is_addr_q <= is_addr_d;
      rd_ph_q   <= rd_ph_d;
      second_q  <= second_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      ack_bad_q <= ack_bad_d;
      busy_q    <= busy_d;
      done_q    <= done_d;
      nack_q    <= nack_d;
      rxv_q     <= rxv_d;
      take_q    <= take_d;
      req_q     <= req_d;
    end
  end

  // Open-drain lines: the drive value is always low and only the enable moves.
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_n = !scl_low_q;
  assign sda_oe_n = !sda_low_q;
  assign tx_take  = take_q;
  assign rx_byte  = rx_q;
  assign rx_valid = rxv_q;
  assign busy     = busy_q;
  assign done     = done_q;
  assign nack_err = nack_q;
  assign clk_req  = req_q;

endmodule

// file: pkg/two_wire_cfg.svh
// Constants for the two-wire bus master: clock rates, timing counts and limits.
// Assumes the core clock runs at 100 MHz; every derived count follows from TW_CORE_HZ.
`ifndef TWO_WIRE_CFG_SVH
`define TWO_WIRE_CFG_SVH

`define TW_CORE_HZ      100000000
`define TW_RATE_100K_HZ 100000
`define TW_RATE_400K_HZ 400000
`define TW_RATE_800K_HZ 800000
`define TW_RATE_1M_HZ   1000000

// Quarter bit period in core cycles, rounded down so the bus never runs slow.
`define TW_QCYC(hz)     (`TW_CORE_HZ / (4 * (hz)))

// Data hold after each falling clock edge, a least time, so it rounds up.
`define TW_HOLD_NS      300
`define TW_HOLD_CYC     ((`TW_HOLD_NS * (`TW_CORE_HZ / 1000000) + 999) / 1000)

`define TW_MAX_BYTES    16
`define TW_CNT_W        12

`endif

// file: pkg/two_wire_pkg.sv
// Types shared by the two-wire bus master: sequencer states, transfer kinds, rates.
// Numeric constants live in two_wire_cfg.svh.
package two_wire_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_START   = 3'h1,
    ST_BYTE    = 3'h2,
    ST_RESTART = 3'h3,
    ST_STOP    = 3'h4
  } tw_state_e;

  typedef enum logic [1:0] {
    XF_READ  = 2'h0,
    XF_WRITE = 2'h1,
    XF_RD_WR = 2'h2,
    XF_WR_RD = 2'h3
  } xfer_e;

  typedef enum logic [1:0] {
    RATE_100K = 2'h0,
    RATE_400K = 2'h1,
    RATE_800K = 2'h2,
    RATE_1M   = 2'h3
  } rate_e;

endpackage

// file: verification/two_wire_master_sva.sv
// Port assertions for the two-wire master.
// One clock domain; bound to every instance below.
`timescale 1ns/1ps
module two_wire_master_sva #(
  parameter int MAX_BYTES = 16
) (
  input wire logic                core_clk,  // Clock.
  input wire logic                arst_n,    // Reset.
  input wire logic                enable,    // Enable.
  input wire logic                start,     // Start.
  input wire two_wire_pkg::xfer_e xfer_type, // Kind.
  input wire logic [4:0]          rd_len,    // Reads.
  input wire logic [4:0]          wr_len,    // Writes.
  input wire logic                tx_take,   // Taken.
  input wire logic                rx_valid,  // Read.
  input wire logic                busy,      // Busy.
  input wire logic                done,      // Done.
  input wire logic                nack_err,  // Nack.
  input wire logic                clk_req,   // Request.
  input wire logic                scl_oe_n,  // Clock pull.
  input wire logic                sda_oe_n   // Data pull.
);
  // Thirty cycles of 10 ns give the full 300 ns hold after the clock line falls.
  localparam int HOLD_CHK = 30;
  logic [5:0] low_q;
  logic [5:0] low_d;
  logic       rd_ok;
  logic       wr_ok;
  // Saturates so a long low phase never wraps into a short one.
  always_comb low_d = scl_oe_n ? 6'h00 : low_q + {5'h00, low_q != 6'h3F};
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) low_q <= 6'h00;
    else low_q <= low_d;
  assign rd_ok = xfer_type == two_wire_pkg::XF_WRITE || (rd_len != 5'h00 && rd_len <= MAX_BYTES);
  assign wr_ok = xfer_type == two_wire_pkg::XF_READ || (wr_len != 5'h00 && wr_len <= MAX_BYTES);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_start_cond;
    (scl_oe_n && sda_oe_n) [*8] ##[1:1000] (scl_oe_n && !sda_oe_n);
  endsequence
  AST_IDLE_FREE: assert property (!busy |-> scl_oe_n && sda_oe_n)
    else $error("line pulled while idle");
  AST_CLK_REQ: assert property ($past(arst_n) |-> clk_req == $past(enable))
    else $error("request does not follow enable");
  AST_ACCEPT: assert property (start && enable && !busy && rd_ok && wr_ok
    |=> busy && !nack_err) else $error("start not taken");
  AST_GATED: assert property (!enable && !busy |=> !busy)
    else $error("ran while disabled");
  AST_DONE_END: assert property (done |-> $past(busy) && !busy ##1 !done)
    else $error("bad done pulse");
  AST_START_COND: assert property ($rose(busy) |-> s_start_cond)
    else $error("no start condition");
  AST_DATA_HOLD: assert property (!scl_oe_n && low_q < HOLD_CHK |-> $stable(sda_oe_n))
    else $error("data moved in hold time");
  AST_STREAM: assert property (tx_take || rx_valid |-> busy ##1 !(tx_take || rx_valid))
    else $error("bad stream pulse");
endmodule

bind two_wire_master two_wire_master_sva #(.MAX_BYTES(MAX_BYTES)) u_sva (
  .core_clk, .arst_n, .enable, .start, .xfer_type, .rd_len, .wr_len, .tx_take,
  .rx_valid, .busy, .done, .nack_err, .clk_req, .scl_oe_n, .sda_oe_n
);

// file: verification/tw_slave.sv
// Behavioural two-wire slave answering one address.
// Sees the resolved lines and only ever pulls data low.
`timescale 1ns/1ps
module tw_slave #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic scl,     // Clock line.
  input  wire logic sda,     // Data line.
  output logic      sda_pull // Pull data low.
);
  logic [7:0] sh;
  logic [7:0] tx;
  logic       act = 1'b0;
  logic       adr;
  logic       rd;
  int         bc;
  logic [7:0] got[$];
  initial sda_pull = 1'b0;
  always @(negedge sda)
    if (scl)
    begin
      act = 1'b1;
      adr = 1'b1;
      rd = 1'b0;
      bc = -1;
      tx = 8'hA0;
    end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act && !rd && bc < 8) sh = {sh[6:0], sda};
  // A master NACK ends the read, so the model lets go of the data line until the next start.
  always @(posedge scl) if (act && rd && bc == 8 && sda) act = 1'b0;
  always @(negedge scl)
    if (act)
    begin
      bc = (bc == 8) ? 0 : bc + 1;
      sda_pull = 1'b0;
      if (bc == 8 && rd) tx = tx + 8'h01;
      if (bc == 8 && !rd) sda_pull = !adr || sh[7:1] == ADDR;
      if (bc == 8 && !rd && !adr) got.push_back(sh);
      if (bc == 8 && adr) {act, rd} = {sh[7:1] == ADDR, sh[0]};
      if (bc == 8) adr = 1'b0;
      if (bc < 8 && rd) sda_pull = ~tx[7 - bc];
    end
endmodule

// file: verification/tb.sv
// Bench for the two-wire master with a behavioural slave.
// One 100 MHz clock; the slave answers address 2A only.
`timescale 1ns/1ps
module tb;
  logic                core_clk = 1'b0, arst_n = 1'b0, enable = 1'b1, start = 1'b0;
  two_wire_pkg::xfer_e xfer_type = two_wire_pkg::XF_READ;
  two_wire_pkg::rate_e rate = two_wire_pkg::RATE_1M;
  logic [6:0]          slave_addr = 7'h2A;
  logic [4:0]          rd_len = 5'h01, wr_len = 5'h01;
  logic [7:0]          tx_byte = 8'hC0, rx_byte;
  logic                tx_take, rx_valid, busy, done, nack_err, clk_req, sda_pull;
  logic                scl_o, scl_oe_n, sda_o, sda_oe_n;
  wire                 scl_w, sda_w;
  logic [7:0]          rxq[$];
  int                  num_errors = 0, tests_run = 0, cyc = 0;
  time                 scl_prev = 0, scl_per = 0;
  // Board resistors hold both lines high; every party may only pull low.
  assign scl_w = scl_oe_n | scl_o;
  assign sda_w = (sda_oe_n | sda_o) & ~sda_pull;
  two_wire_master DUT (
    .core_clk, .arst_n, .enable, .start, .xfer_type, .rate, .slave_addr, .rd_len, .wr_len,
    .tx_byte, .tx_take, .rx_byte, .rx_valid, .busy, .done, .nack_err, .clk_req,
    .scl_i(scl_w), .scl_o, .scl_oe_n, .sda_i(sda_w), .sda_o, .sda_oe_n
  );
  tw_slave #(.ADDR(7'h2A)) slv (.scl(scl_w), .sda(sda_w), .sda_pull);
  always #5 core_clk = ~core_clk;
  always @(negedge scl_w)
  begin
    scl_per = $time - scl_prev;
    scl_prev = $time;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (tx_take === 1'b1) tx_byte <= #1 tx_byte + 8'h01;
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (cyc == 90000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic chk_q(input logic [7:0] q[$], input int n, input logic [7:0] base);
    chk(q.size() == n, "byte count");
    foreach (q[i]) chk(q[i] === base + 8'(i), "byte value");
  endtask
  task automatic run(input two_wire_pkg::xfer_e t, input two_wire_pkg::rate_e r,
                     input logic [6:0] a, input logic [4:0] rl, input logic [4:0] wl);
    int per_ns;
    rxq.delete();
    slv.got.delete();
    xfer_type = t;
    rate = r;
    slave_addr = a;
    rd_len = rl;
    wr_len = wl;
    tx_byte = 8'hC0;
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    do @(negedge core_clk); while (done !== 1'b1);
    @(posedge core_clk);
    #1;
    // The last clock period before the stop is one whole bit; it may run short, never long.
    per_ns = (r == two_wire_pkg::RATE_100K) ? 10000 : (r == two_wire_pkg::RATE_400K) ? 2500
           : (r == two_wire_pkg::RATE_800K) ? 1250 : 1000;
    chk(scl_per <= per_ns && scl_per * 50 >= per_ns * 49, "bus rate");
  endtask
  task automatic t_reset();
    chk(scl_oe_n === 1'b1 && sda_oe_n === 1'b1 && busy === 1'b0, "lines held");
    chk(clk_req === 1'b1 && scl_w === 1'b1 && sda_w === 1'b1, "idle levels");
    chk(scl_o === 1'b0 && sda_o === 1'b0, "line driven high");
    $display("reset test finished");
  endtask
  task automatic t_write16();
    run(two_wire_pkg::XF_WRITE, two_wire_pkg::RATE_1M, 7'h2A, 5'h01, 5'h10);
    chk_q(slv.got, 16, 8'hC0);
    chk(nack_err === 1'b0 && rxq.size() == 0, "write status");
    $display("write test finished");
  endtask
  task automatic t_nack();
    run(two_wire_pkg::XF_WRITE, two_wire_pkg::RATE_1M, 7'h15, 5'h01, 5'h01);
    chk(nack_err === 1'b1 && slv.got.size() == 0, "nack missed");
    $display("nack test finished");
  endtask
  task automatic t_read();
    run(two_wire_pkg::XF_READ, two_wire_pkg::RATE_400K, 7'h2A, 5'h02, 5'h01);
    chk_q(rxq, 2, 8'hA0);
    chk(nack_err === 1'b0, "nack kept");
    $display("read test finished");
  endtask
  task automatic t_wr_rd();
    run(two_wire_pkg::XF_WR_RD, two_wire_pkg::RATE_800K, 7'h2A, 5'h01, 5'h02);
    chk_q(slv.got, 2, 8'hC0);
    chk_q(rxq, 1, 8'hA0);
    $display("write-read test finished");
  endtask
  task automatic t_rd_wr();
    run(two_wire_pkg::XF_RD_WR, two_wire_pkg::RATE_100K, 7'h2A, 5'h01, 5'h01);
    chk_q(rxq, 1, 8'hA0);
    chk_q(slv.got, 1, 8'hC0);
    $display("read-write test finished");
  endtask
  task automatic t_disabled();
    enable = 1'b0;
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    @(posedge core_clk);
    #1 chk(clk_req === 1'b0 && busy === 1'b0, "ran disabled");
    enable = 1'b1;
    @(posedge core_clk);
    #1 chk(clk_req === 1'b1 && busy === 1'b0, "request low");
    xfer_type = two_wire_pkg::XF_READ;
    rd_len = 5'h11;
    start = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    @(posedge core_clk);
    #1 chk(busy === 1'b0 && done === 1'b0, "bad length taken");
    $display("disable test finished");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1 arst_n = 1'b1;
    @(posedge core_clk);
    #1 t_reset();
    t_write16();
    t_nack();
    t_read();
    t_wr_rd();
    t_rd_wr();
    t_disabled();
    tally_and_finish();
  end
endmodule
